//--- rtl/olcs_top.sv
// Open-loop commutation sequencer with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module olcs_top
    import olcs_pkg::*;
#(
    parameter int unsigned PWM_CYCLES = PWM_PERIOD_CYCLES
)(
    input  wire logic        mclk_in,          // System clock, 100 MHz
    input  wire logic        reset_in,         // Async reset, high
    input  wire logic [7:0]  s_axi_awaddr_in,  // Write address
    input  wire logic        s_axi_awvalid_in, // Write address valid
    output logic             s_axi_awready_out, // Write address ready
    input  wire logic [31:0] s_axi_wdata_in,   // Write data
    input  wire logic [3:0]  s_axi_wstrb_in,   // Write byte strobes
    input  wire logic        s_axi_wvalid_in,  // Write data valid
    output logic             s_axi_wready_out, // Write data ready
    output logic [1:0]       s_axi_bresp_out,  // Write response
    output logic             s_axi_bvalid_out, // Write response valid
    input  wire logic        s_axi_bready_in,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr_in,  // Read address
    input  wire logic        s_axi_arvalid_in, // Read address valid
    output logic             s_axi_arready_out, // Read address ready
    output logic [31:0]      s_axi_rdata_out,  // Read data
    output logic [1:0]       s_axi_rresp_out,  // Read response
    output logic             s_axi_rvalid_out, // Read data valid
    input  wire logic        s_axi_rready_in,  // Read data ready
    output logic [5:0]       pwm_out           // Inverter gate outputs 1..6
);
    localparam int unsigned TW = $clog2(TICK_CYCLES);

    // Software settings
    logic        run_enable;
    logic [15:0] target_period;
    logic [15:0] ramp_step_delay;
    logic [15:0] startup_duty;
    logic [15:0] start_period;

    // Block state
    logic [TW-1:0] tick_div;
    logic          service_tick;
    logic [31:0]   service_tick_counter;
    logic [15:0]   ramp_out;
    logic [15:0]   step_cnt;
    logic          ramp_step;
    logic [15:0]   ramp_complete_flag;
    logic [15:0]   impulse_cnt;
    logic          impulse;
    olcs_index_t   six_state_counter;

    // AXI write path
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;

    olcs_drv_if drv_bus ();

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16[7:0]  = s[0] ? d[7:0]  : old[7:0];
        merge16[15:8] = s[1] ? d[15:8] : old[15:8];
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        case (a)
            OFS_CTRL, OFS_TARGET, OFS_DELAY, OFS_DUTY,
            OFS_START, OFS_STATUS, OFS_PERIOD, OFS_TICKS: known_addr = 1'b1;
            default:                                      known_addr = 1'b0;
        endcase
    endfunction

    // Write address and data are taken in either order
    assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
    assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
    assign wr_fire           = aw_held && w_held && !s_axi_bvalid_out;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= known_addr(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // Settings registers; read-only offsets ignore writes
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            run_enable      <= 1'b0;
            target_period   <= TARGET_RST;
            ramp_step_delay <= DELAY_RST;
            startup_duty    <= DUTY_RST;
            start_period    <= START_RST;
        end else if (wr_fire) begin
            case (aw_addr)
                OFS_CTRL: begin
                    if (w_strb[0]) begin
                        run_enable <= w_data[CTRL_RUN_BIT];
                    end
                end
                OFS_TARGET: target_period   <= merge16(target_period, w_data, w_strb);
                OFS_DELAY:  ramp_step_delay <= merge16(ramp_step_delay, w_data, w_strb);
                OFS_DUTY:   startup_duty    <= merge16(startup_duty, w_data, w_strb);
                OFS_START:  start_period    <= merge16(start_period, w_data, w_strb);
                default: begin
                end
            endcase
        end
    end

    // Read path: one word per read, answered the cycle after acceptance
    assign s_axi_arready_out = !s_axi_rvalid_out;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h0000_0000;
            s_axi_rresp_out  <= RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= known_addr(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr_in)
                OFS_CTRL:   s_axi_rdata_out <= {31'h0000_0000, run_enable};
                OFS_TARGET: s_axi_rdata_out <= {16'h0000, target_period};
                OFS_DELAY:  s_axi_rdata_out <= {16'h0000, ramp_step_delay};
                OFS_DUTY:   s_axi_rdata_out <= {16'h0000, startup_duty};
                OFS_START:  s_axi_rdata_out <= {16'h0000, start_period};
                OFS_STATUS: s_axi_rdata_out <= {13'h0000, six_state_counter, ramp_complete_flag};
                OFS_PERIOD: s_axi_rdata_out <= {16'h0000, ramp_out};
                OFS_TICKS:  s_axi_rdata_out <= service_tick_counter;
                default:    s_axi_rdata_out <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // Service tick divider, free running
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            tick_div     <= '0;
            service_tick <= 1'b0;
        end else if (tick_div == TW'(TICK_CYCLES - 1)) begin
            tick_div     <= '0;
            service_tick <= 1'b1;
        end else begin
            tick_div     <= tick_div + 1'b1;
            service_tick <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            service_tick_counter <= 32'h0000_0000;
        end else if (run_enable && service_tick) begin
            service_tick_counter <= service_tick_counter + 32'h0000_0001;
        end
    end

    // Ramp-down generator
    assign ramp_step = run_enable && service_tick && (step_cnt >= ramp_step_delay);

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            step_cnt <= 16'h0000;
        end else if (!run_enable) begin
            step_cnt <= 16'h0000;
        end else if (ramp_step) begin
            step_cnt <= 16'h0000;
        end else if (service_tick) begin
            step_cnt <= step_cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ramp_out <= START_RST;
        end else if (!run_enable) begin
            ramp_out <= start_period;
        end else if (ramp_step && (ramp_out > target_period)) begin
            ramp_out <= ramp_out - 16'h0001;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ramp_complete_flag <= 16'h0000;
        end else begin
            ramp_complete_flag <= (run_enable && ramp_out == target_period) ? RAMP_DONE_VAL
                                                                            : 16'h0000;
        end
    end

    // Impulse generator: one clock-wide pulse per ramp_out ticks
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            impulse_cnt <= 16'h0000;
            impulse     <= 1'b0;
        end else if (!run_enable) begin
            impulse_cnt <= 16'h0000;
            impulse     <= 1'b0;
        end else if (service_tick) begin
            if (impulse_cnt + 16'h0001 >= ramp_out) begin
                impulse_cnt <= 16'h0000;
                impulse     <= 1'b1;
            end else begin
                impulse_cnt <= impulse_cnt + 16'h0001;
                impulse     <= 1'b0;
            end
        end else begin
            impulse <= 1'b0;
        end
    end

    // Six-state counter
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            six_state_counter <= 3'h0;
        end else if (impulse) begin
            six_state_counter <= (six_state_counter >= LAST_STATE) ? 3'h0
                                                                   : six_state_counter + 3'h1;
        end
    end

    assign drv_bus.commutation_index = six_state_counter;
    assign drv_bus.startup_duty      = startup_duty;
    assign drv_bus.run_enable        = run_enable;

    olcs_pwm_drv #(
        .PWM_CYCLES (PWM_CYCLES)
    ) u_drv (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .drv      (drv_bus.drv),
        .pwm_out  (pwm_out)
    );

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    a_index_range: assert property (six_state_counter <= LAST_STATE)
        else $error("Commutation index outside 0..5");
    a_index_advance: assert property (impulse |=> six_state_counter ==
            (($past(six_state_counter) == LAST_STATE) ? 3'h0 : $past(six_state_counter) + 3'h1))
        else $error("Index did not advance by one on impulse");
    a_index_hold: assert property (!impulse |=> $stable(six_state_counter))
        else $error("Index moved without an impulse");
    a_ramp_stepdown: assert property (ramp_step && ramp_out > target_period
                                      |=> ramp_out == $past(ramp_out) - 16'h0001)
        else $error("Ramp did not drop by one on its step");
    a_ramp_floor: assert property (run_enable && $past(run_enable) && ramp_out != $past(ramp_out)
                                   |-> $past(ramp_out) > $past(target_period))
        else $error("Ramp moved while at or below target");
    a_done_flag: assert property (run_enable && ramp_out == target_period
                                  |=> ramp_complete_flag == RAMP_DONE_VAL)
        else $error("Completion flag not set at target");
    a_impulse_tick: assert property (impulse |-> $past(service_tick) ##1 !impulse)
        else $error("Impulse not a single pulse on a tick");
    a_tick_count: assert property (run_enable && service_tick
                                   |=> service_tick_counter == $past(service_tick_counter) + 1)
        else $error("Tick counter did not increment");
    a_tick_space: assert property (service_tick |=> !service_tick [*8])
        else $error("Service ticks too close");
    a_tick_hold: assert property (!service_tick |=> $stable(service_tick_counter))
        else $error("Tick counter moved between ticks");
    a_ramp_hold: assert property (run_enable && !ramp_step |=> $stable(ramp_out))
        else $error("Ramp moved without a step");
    a_ramp_reload: assert property (!run_enable |=> ramp_out == $past(start_period))
        else $error("Ramp not reloaded while stopped");
    a_step_clear: assert property (ramp_step |=> step_cnt == 16'h0000)
        else $error("Step counter not cleared after a step");
    a_flag_clear: assert property (!(run_enable && ramp_out == target_period)
                                   |=> ramp_complete_flag == 16'h0000)
        else $error("Completion flag set away from target");
    a_impulse_idle: assert property (!run_enable |=> !impulse)
        else $error("Impulse while stopped");

    // Read data comes one cycle after the address is taken, the write response one cycle after both halves are held; both stand until taken
    a_write_answer: assert property (wr_fire |=> s_axi_bvalid_out)
        else $error("Write response missing after both halves held");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("Read data missing after address taken");
    a_bresp_stand: assert property (s_axi_bvalid_out && !s_axi_bready_in
                                    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("Write response dropped before taken");
    a_rdata_stand: assert property (s_axi_rvalid_out && !s_axi_rready_in
                                    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("Read data dropped before taken");

    c_ramp_done: cover property (ramp_complete_flag == RAMP_DONE_VAL);
    c_index_wrap: cover property (impulse && six_state_counter == LAST_STATE);
    c_write_read: cover property (wr_fire ##[1:20] s_axi_rvalid_out);
    c_retarget: cover property (run_enable && $fell(ramp_complete_flag == RAMP_DONE_VAL));
    c_stop: cover property ($fell(run_enable));
endmodule

//--- include/olcs_pkg.sv
// Constants, register map and types of the open-loop commutation sequencer
package olcs_pkg;
    // Clock and pacing
    localparam int unsigned CLK_HZ            = 100_000_000;
    localparam int unsigned TICK_RATE_HZ      = 40_000;
    localparam int unsigned TICK_CYCLES       = CLK_HZ / TICK_RATE_HZ;
    localparam int unsigned PWM_RATE_HZ       = 20_000;
    localparam int unsigned PWM_PERIOD_CYCLES = CLK_HZ / PWM_RATE_HZ;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_TARGET = 8'h04;
    localparam logic [7:0] OFS_DELAY  = 8'h08;
    localparam logic [7:0] OFS_DUTY   = 8'h0C;
    localparam logic [7:0] OFS_START  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_PERIOD = 8'h18;
    localparam logic [7:0] OFS_TICKS  = 8'h1C;

    // Field positions
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned STAT_FLAG_LSB  = 0;
    localparam int unsigned STAT_INDEX_LSB = 16;

    // Reset values
    localparam logic [15:0] TARGET_RST = 16'h0100;
    localparam logic [15:0] DELAY_RST  = 16'h0005;
    localparam logic [15:0] DUTY_RST   = 16'h1000;
    localparam logic [15:0] START_RST  = 16'h0FFF;

    // Values
    localparam logic [15:0] RAMP_DONE_VAL = 16'h7FFF;
    localparam logic [2:0]  LAST_STATE    = 3'h5;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef logic [2:0] olcs_index_t;
endpackage

//--- include/olcs_drv_if.sv
// Carrier between the sequencer core and the commutation PWM driver
`timescale 1ns/10ps
interface olcs_drv_if;
    import olcs_pkg::*;
    olcs_index_t commutation_index;
    logic [15:0] startup_duty;
    logic        run_enable;
    modport core (output commutation_index, output startup_duty, output run_enable);
    modport drv  (input commutation_index, input startup_duty, input run_enable);
endinterface

//--- rtl/olcs_pwm_drv.sv
// Commutation PWM driver: six outputs from commutation index and duty
`timescale 1ns/10ps
module olcs_pwm_drv
    import olcs_pkg::*;
#(
    parameter int unsigned PWM_CYCLES = PWM_PERIOD_CYCLES
)(
    input  wire logic       mclk_in,   // System clock
    input  wire logic       reset_in,  // Async reset, high
    olcs_drv_if.drv         drv,       // Index, duty, run
    output logic [5:0]      pwm_out    // Bit0 = output 1 ... bit5 = output 6
);
    localparam int unsigned CW = $clog2(PWM_CYCLES + 1);

    logic [CW-1:0] carrier;
    logic [5:0]    next_pwm;
    logic [5:0]    sel_map;

    // Low-side phase mask above high-side phase mask, A in bit 0
    function automatic logic [5:0] phase_map(input olcs_index_t idx);
        case (idx)
            3'h0:    phase_map = {3'b010, 3'b001};
            3'h1:    phase_map = {3'b100, 3'b001};
            3'h2:    phase_map = {3'b100, 3'b010};
            3'h3:    phase_map = {3'b001, 3'b010};
            3'h4:    phase_map = {3'b001, 3'b100};
            3'h5:    phase_map = {3'b010, 3'b100};
            default: phase_map = 6'h00;
        endcase
    endfunction

    // Q15 duty to carrier counts
    function automatic logic [CW-1:0] duty_counts(input logic [15:0] duty);
        logic [47:0] prod;
        prod        = 48'(duty) * 48'(PWM_CYCLES);
        duty_counts = CW'(prod >> 15);
    endfunction

    // Edge-aligned up-counting carrier
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            carrier <= '0;
        end else if (carrier == CW'(PWM_CYCLES - 1)) begin
            carrier <= '0;
        end else begin
            carrier <= carrier + 1'b1;
        end
    end

    always_comb begin
        logic [5:0] m;
        logic       on;
        m        = phase_map(drv.commutation_index);
        on       = carrier < duty_counts(drv.startup_duty);
        next_pwm = '0;
        for (int p = 0; p < 3; p++) begin
            next_pwm[2*p]   = m[p] & on;
            next_pwm[2*p+1] = m[3+p];
        end
        if (!drv.run_enable) begin
            next_pwm = '0;
        end
    end

    // No dead band: a complementary pair never switches together
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pwm_out <= '0;
        end else begin
            pwm_out <= next_pwm;
        end
    end

    // Phase masks of the present index, for the checks below
    assign sel_map = phase_map(drv.commutation_index);

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    a_carrier_wrap: assert property (carrier == CW'(PWM_CYCLES - 1) |=> carrier == '0)
        else $error("Carrier did not wrap at its period");
    a_odd_gated: assert property (({pwm_out[4], pwm_out[2], pwm_out[0]}
                                   & ~$past(sel_map[2:0])) == 3'h0)
        else $error("Unselected high-side output pulsed");
    a_even_static: assert property ($stable(drv.commutation_index) && $stable(drv.run_enable)
                                    |=> $stable(pwm_out[1]) && $stable(pwm_out[3]) && $stable(pwm_out[5]))
        else $error("Low-side output changed without a state change");
endmodule

//--- verification/olcs_inverter_model.sv
// Behavioural three-phase inverter fed by the six gate outputs
`timescale 1ns/10ps
module olcs_inverter_model (
    input  wire logic        mclk_in,   // System clock
    input  wire logic        reset_in,  // Async reset, high
    input  wire logic [5:0]  gate_in,   // Bit0 = output 1 ... bit5 = output 6
    output logic      [2:0]  high_out,  // Upper switch closed, phase A..C
    output logic      [2:0]  low_out,   // Lower switch closed, phase A..C
    output logic      [15:0] short_out  // Cycles with a leg shorted
);
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            high_out[p] = gate_in[2*p];
            low_out[p]  = gate_in[2*p+1];
        end
    end

    // A leg with both switches closed shorts the bus
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            short_out <= 16'h0000;
        end else if ((high_out & low_out) != 3'h0) begin
            short_out <= short_out + 16'h0001;
        end
    end
endmodule

//--- verification/tb_top.sv
// Self-checking bench of the open-loop commutation sequencer
`timescale 1ns/10ps
module tb_top;
    import olcs_pkg::*;
    localparam int PWMC = 50;
    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [5:0]  pwm;
    logic [2:0]  hi_leg, lo_leg, idx;
    logic [15:0] shorts;
    int          bad_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          t, n, last;
    int          hi_t [6] = '{0, 0, 2, 2, 4, 4};
    int          lo_t [6] = '{3, 5, 5, 1, 1, 3};

    always #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) cyc <= cyc + 1;

    olcs_top #(.PWM_CYCLES(PWMC)) dut (.mclk_in(mclk_in), .reset_in(reset_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pwm_out(pwm));

    olcs_inverter_model inv (.mclk_in(mclk_in), .reset_in(reset_in), .gate_in(pwm),
        .high_out(hi_leg), .low_out(lo_leg), .short_out(shorts));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        k = 0;
        @(posedge mclk_in);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk_in);
            k++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 200);
        r = bresp;
        bready <= 1'b0;
        if (k >= 200) chk(32'h1, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        k = 0;
        @(posedge mclk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk_in);
            k++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 200);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (k >= 200) chk(32'h1, 32'h0);
    endtask

    task automatic wait_ticks(input int m);
        int k;
        k = 0;
        do begin
            rd(OFS_TICKS);
            k++;
        end while (d < m && k < 30000);
        if (d < m) chk(d, m);
    endtask

    // Two carrier periods: pulsed leg high half the time, static leg always
    task automatic scan(input int hi, input int lo);
        int cnt [6];
        cnt = '{default: 0};
        repeat (2 * PWMC) begin
            @(posedge mclk_in);
            for (int b = 0; b < 6; b++) cnt[b] += (pwm[b] === 1'b1);
        end
        for (int b = 0; b < 6; b++) begin
            chk(cnt[b], (b == hi) ? PWMC : ((b == lo) ? 2 * PWMC : 0));
        end
    endtask

    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (38 * TICK_CYCLES) @(posedge mclk_in);
        bad_count++;
        $display("BAD t=%0t watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (12) @(posedge mclk_in);
        reset_in <= 1'b0;
        rd(OFS_STATUS);
        chk(d, 32'h0);
        rd(OFS_TARGET);
        chk(d, {16'h0, TARGET_RST});
        rd(OFS_START);
        chk(d, {16'h0, START_RST});
        rd(8'h20);
        chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        wr(8'h24, 32'h1);
        chk(r, RESP_SLVERR);
        wr(OFS_TICKS, 32'hFF);
        chk(r, RESP_OKAY);
        rd(OFS_TICKS);
        chk(d, 32'h0);
        scan(-1, -1);
        $display("Test reset state done");
        wr(OFS_START, 32'h4);
        wr(OFS_TARGET, 32'h2);
        wr(OFS_DELAY, 32'h1);
        wr(OFS_DUTY, 32'h4000);
        wr(OFS_CTRL, 32'h1);
        wait_ticks(2);
        rd(OFS_PERIOD);
        chk(d, 32'h3);
        rd(OFS_STATUS);
        chk(d[15:0], 16'h0);
        wait_ticks(6);
        rd(OFS_PERIOD);
        chk(d, 32'h2);
        rd(OFS_STATUS);
        chk(d[15:0], RAMP_DONE_VAL);
        $display("Test ramp done");
        idx = d[18:16];
        last = 0;
        for (int k = 0; k < 8; k++) begin
            n = 0;
            do begin
                rd(OFS_STATUS);
                n++;
            end while (d[18:16] === idx && n < 4000);
            chk(d[18:16], (idx == LAST_STATE) ? 3'h0 : idx + 3'h1);
            if (k > 0) chk((cyc - last + TICK_CYCLES / 2) / TICK_CYCLES, 2);
            last = cyc;
            idx = d[18:16];
            if (idx <= LAST_STATE) scan(hi_t[idx], lo_t[idx]);
        end
        $display("Test commutation done");
        wr(OFS_TARGET, 32'h1);
        rd(OFS_PERIOD);
        chk(d, 32'h2);
        rd(OFS_TICKS);
        t = int'(d);
        wait_ticks(t + 3);
        rd(OFS_PERIOD);
        chk(d, 32'h1);
        rd(OFS_STATUS);
        chk(d[15:0], RAMP_DONE_VAL);
        $display("Test retarget done");
        wr(OFS_CTRL, 32'h0);
        repeat (3) @(posedge mclk_in);
        scan(-1, -1);
        chk(shorts, 16'h0);
        $display("Test stop done");
        close_out();
    end
endmodule
